// >>> rtl/fcsl_pkg.sv
// Functional notes
// - broken command sequence sets error, drops command
// - program or erase before divider write errors
// - stop during running command sets error
// - write one clears error; zero does nothing
// - erased array at blank check end sets blank
// - blank clears at valid command launch, unless a blank check on an erased array ends in that cycle, and at a blank check end with the array not erased
// - blank reads one only if all erased
// - accept blank 0x05, program 0x20, burst 0x25
// - accept erase 0x40, mass 0x41, abort 0x47
// - any other code rejected with error
package fcsl_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CLK_DIV = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;

    localparam int BIT_CBEF = 7;
    localparam int BIT_CCF = 6;
    localparam int BIT_ACCERR = 4;
    localparam int BIT_BLANK = 2;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_W = 2;

    localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
    localparam logic [7:0] CMD_SINGLE_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    localparam logic [7:0] CMD_SECTOR_ERASE_ABORT = 8'h47;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CLK_DIV = 8'h00;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_RUN = 2'b10
    } fcsl_eng_t;

    typedef struct packed {
        logic legal;
        logic prog_erase;
        logic blank;
    } fcsl_dec_t;

    typedef struct packed {
        logic start;
        logic [7:0] code;
    } fcsl_cmd_t;
endpackage : fcsl_pkg

// >>> rtl/fcsl_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module fcsl_decoder (
    input wire logic [7:0] i_code,
    output fcsl_pkg::fcsl_dec_t o_dec
);
    always_comb begin
        o_dec = '0;
        case (i_code)
            fcsl_pkg::CMD_BLANK_CHECK: begin
                o_dec.legal = 1'b1;
                o_dec.blank = 1'b1;
            end
            fcsl_pkg::CMD_SINGLE_PROGRAM, fcsl_pkg::CMD_BURST_PROGRAM: begin
                o_dec.legal = 1'b1;
                o_dec.prog_erase = 1'b1;
            end
            fcsl_pkg::CMD_SECTOR_ERASE, fcsl_pkg::CMD_MASS_ERASE: begin
                o_dec.legal = 1'b1;
                o_dec.prog_erase = 1'b1;
            end
            fcsl_pkg::CMD_SECTOR_ERASE_ABORT: begin
                o_dec.legal = 1'b1;
            end
            default: begin
                o_dec = '0;
            end
        endcase
    end
endmodule : fcsl_decoder
`default_nettype wire

// >>> rtl/fcsl_top.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fcsl_top (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [fcsl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fcsl_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [fcsl_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_engine_done,
    input wire logic i_array_erased,
    input wire logic i_stop_req,
    output fcsl_pkg::fcsl_cmd_t o_cmd,
    output logic o_engine_abort,
    output logic [7:0] o_clk_div,
    output logic o_irq
);
    fcsl_pkg::fcsl_eng_t state_r, state_nxt;
    fcsl_pkg::fcsl_dec_t wr_dec;
    fcsl_pkg::fcsl_dec_t run_dec;
    fcsl_pkg::fcsl_cmd_t cmd_nxt;
    logic cbef_r, cbef_nxt;
    logic ccf_r, ccf_nxt;
    logic accerr_r, accerr_nxt;
    logic blank_r, blank_nxt;
    logic cmd_valid_r, cmd_valid_nxt;
    logic pending_r, pending_nxt;
    logic div_set_r, div_set_nxt;
    logic abort_nxt;
    logic [7:0] cmd_code_r, cmd_code_nxt;
    logic [7:0] run_code_r, run_code_nxt;
    logic [7:0] clk_div_r, clk_div_nxt;
    logic [fcsl_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [fcsl_pkg::IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic irq_nxt;
    logic [7:0] rd_data_nxt;
    logic wr_status;
    logic launch;
    logic cmd_write;
    logic acc_set;
    logic done_ev;
    logic [fcsl_pkg::IRQ_W-1:0] irq_ev;

    fcsl_decoder u_wr_dec (
        .i_code(i_wr_data),
        .o_dec(wr_dec)
    );

    fcsl_decoder u_run_dec (
        .i_code(run_code_r),
        .o_dec(run_dec)
    );

    assign wr_status = i_wr && (i_addr == fcsl_pkg::OFS_STATUS);
    assign cmd_write = i_wr && (i_addr == fcsl_pkg::OFS_COMMAND);
    assign launch = wr_status && i_wr_data[fcsl_pkg::BIT_CBEF] && cbef_r;

    always_comb begin
        state_nxt = state_r;
        cbef_nxt = cbef_r;
        accerr_nxt = accerr_r;
        blank_nxt = blank_r;
        cmd_valid_nxt = cmd_valid_r;
        pending_nxt = pending_r;
        div_set_nxt = div_set_r;
        cmd_code_nxt = cmd_code_r;
        run_code_nxt = run_code_r;
        clk_div_nxt = clk_div_r;
        cmd_nxt = '0;
        abort_nxt = 1'b0;
        acc_set = 1'b0;
        done_ev = 1'b0;

        if (i_wr && (i_addr == fcsl_pkg::OFS_CLK_DIV)) begin
            clk_div_nxt = i_wr_data;
            div_set_nxt = 1'b1;
        end

        // command loaded only into an empty buffer with no error pending
        if (cmd_write && !accerr_r) begin
            if (!cbef_r || cmd_valid_r) begin
                acc_set = 1'b1;
            end else if (!wr_dec.legal) begin
                acc_set = 1'b1;
            end else if (wr_dec.prog_erase && !div_set_r) begin
                acc_set = 1'b1;
            end else begin
                cmd_code_nxt = i_wr_data;
                cmd_valid_nxt = 1'b1;
            end
        end

        if (launch) begin
            if (!cmd_valid_r) begin
                acc_set = 1'b1;
            end else begin
                cmd_valid_nxt = 1'b0;
                blank_nxt = 1'b0;
                if (state_r == fcsl_pkg::ENG_IDLE) begin
                    cmd_nxt.start = 1'b1;
                    cmd_nxt.code = cmd_code_r;
                    run_code_nxt = cmd_code_r;
                    state_nxt = fcsl_pkg::ENG_RUN;
                end else begin
                    pending_nxt = 1'b1; // buffer full until engine takes it
                    cbef_nxt = 1'b0;
                end
            end
        end

        case (state_r)
            fcsl_pkg::ENG_IDLE: begin
                state_nxt = launch && cmd_valid_r ? fcsl_pkg::ENG_RUN : fcsl_pkg::ENG_IDLE;
            end
            fcsl_pkg::ENG_RUN: begin
                if (i_stop_req) begin
                    // stop kills running and queued work alike
                    acc_set = 1'b1;
                    abort_nxt = 1'b1;
                    pending_nxt = 1'b0;
                    cbef_nxt = 1'b1;
                    state_nxt = fcsl_pkg::ENG_IDLE;
                end else if (i_engine_done) begin
                    if (run_dec.blank) begin
                        blank_nxt = i_array_erased;
                    end
                    if (pending_r || (launch && cmd_valid_r)) begin
                        cmd_nxt.start = 1'b1;
                        cmd_nxt.code = cmd_code_r;
                        run_code_nxt = cmd_code_r;
                        pending_nxt = 1'b0;
                        cbef_nxt = 1'b1;
                        state_nxt = fcsl_pkg::ENG_RUN;
                    end else begin
                        done_ev = 1'b1;
                        state_nxt = fcsl_pkg::ENG_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = fcsl_pkg::ENG_IDLE;
            end
        endcase

        // set wins over a clear in the same cycle
        if (wr_status && i_wr_data[fcsl_pkg::BIT_ACCERR]) begin
            accerr_nxt = 1'b0;
        end
        if (acc_set) begin
            accerr_nxt = 1'b1;
            cmd_valid_nxt = 1'b0;
        end
    end

    always_comb begin
        ccf_nxt = (state_nxt == fcsl_pkg::ENG_IDLE) && !pending_nxt;
        irq_ev = '0;
        irq_ev[fcsl_pkg::IRQ_DONE] = done_ev;
        irq_ev[fcsl_pkg::IRQ_ERR] = acc_set;
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (i_wr && (i_addr == fcsl_pkg::OFS_IRQ_STATUS)) begin
            irq_stat_nxt = irq_stat_r & ~i_wr_data[fcsl_pkg::IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_ev;
        if (i_wr && (i_addr == fcsl_pkg::OFS_IRQ_MASK)) begin
            irq_mask_nxt = i_wr_data[fcsl_pkg::IRQ_W-1:0];
        end
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    end

    always_comb begin
        rd_data_nxt = fcsl_pkg::RST_BYTE;
        if (i_rd) begin
            case (i_addr)
                fcsl_pkg::OFS_STATUS: begin
                    rd_data_nxt[fcsl_pkg::BIT_CBEF] = cbef_r;
                    rd_data_nxt[fcsl_pkg::BIT_CCF] = ccf_r;
                    rd_data_nxt[fcsl_pkg::BIT_ACCERR] = accerr_r;
                    rd_data_nxt[fcsl_pkg::BIT_BLANK] = blank_r;
                end
                fcsl_pkg::OFS_COMMAND: begin
                    rd_data_nxt = cmd_code_r;
                end
                fcsl_pkg::OFS_CLK_DIV: begin
                    rd_data_nxt = clk_div_r;
                end
                fcsl_pkg::OFS_IRQ_STATUS: begin
                    rd_data_nxt[fcsl_pkg::IRQ_W-1:0] = irq_stat_r;
                end
                fcsl_pkg::OFS_IRQ_MASK: begin
                    rd_data_nxt[fcsl_pkg::IRQ_W-1:0] = irq_mask_r;
                end
                default: begin
                    rd_data_nxt = fcsl_pkg::RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_r <= fcsl_pkg::ENG_IDLE;
            cbef_r <= 1'b1;
            ccf_r <= 1'b1;
            accerr_r <= 1'b0;
            blank_r <= 1'b0;
            cmd_valid_r <= 1'b0;
            pending_r <= 1'b0;
            div_set_r <= 1'b0;
            cmd_code_r <= fcsl_pkg::RST_BYTE;
            run_code_r <= fcsl_pkg::RST_BYTE;
            clk_div_r <= fcsl_pkg::RST_CLK_DIV;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            o_irq <= 1'b0;
            o_rd_data <= fcsl_pkg::RST_BYTE;
            o_cmd <= '0;
            o_engine_abort <= 1'b0;
            o_clk_div <= fcsl_pkg::RST_CLK_DIV;
        end else begin
            state_r <= state_nxt;
            cbef_r <= cbef_nxt;
            ccf_r <= ccf_nxt;
            accerr_r <= accerr_nxt;
            blank_r <= blank_nxt;
            cmd_valid_r <= cmd_valid_nxt;
            pending_r <= pending_nxt;
            div_set_r <= div_set_nxt;
            cmd_code_r <= cmd_code_nxt;
            run_code_r <= run_code_nxt;
            clk_div_r <= clk_div_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            o_irq <= irq_nxt;
            o_rd_data <= rd_data_nxt;
            o_cmd <= cmd_nxt;
            o_engine_abort <= abort_nxt;
            o_clk_div <= clk_div_nxt;
        end
    end
endmodule : fcsl_top
`default_nettype wire

// >>> sim/fcsl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module fcsl_asserts (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [fcsl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fcsl_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [fcsl_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_engine_done,
    input wire logic i_stop_req,
    input wire fcsl_pkg::fcsl_cmd_t o_cmd,
    input wire logic o_engine_abort,
    input wire logic [7:0] o_clk_div,
    input wire logic o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic st_rd = i_rd && i_addr == fcsl_pkg::OFS_STATUS;
    wire logic st_wr = i_wr && i_addr == fcsl_pkg::OFS_STATUS;
    wire logic cmd_wr = i_wr && i_addr == fcsl_pkg::OFS_COMMAND;
    wire logic bad = !(i_wr_data inside {fcsl_pkg::CMD_BLANK_CHECK, fcsl_pkg::CMD_SINGLE_PROGRAM,
        fcsl_pkg::CMD_BURST_PROGRAM, fcsl_pkg::CMD_SECTOR_ERASE, fcsl_pkg::CMD_MASS_ERASE,
        fcsl_pkg::CMD_SECTOR_ERASE_ABORT});
    wire logic out_ok = o_cmd.code inside {fcsl_pkg::CMD_BLANK_CHECK, fcsl_pkg::CMD_SINGLE_PROGRAM,
        fcsl_pkg::CMD_BURST_PROGRAM, fcsl_pkg::CMD_SECTOR_ERASE, fcsl_pkg::CMD_MASS_ERASE,
        fcsl_pkg::CMD_SECTOR_ERASE_ABORT};
    rd_idle_zero_a: assert property (!i_rd |=> o_rd_data == 8'h00) else $error("stray read data");
    start_code_a: assert property (o_cmd.start |-> out_ok) else $error("bad code sent");
    // a write in the gap could clear the flag before the read sees it
    illegal_err_a: assert property ((cmd_wr && bad) ##1 !i_wr ##1 st_rd
        |=> o_rd_data[fcsl_pkg::BIT_ACCERR]) else $error("illegal code no error");
    abort_cause_a: assert property (o_engine_abort |-> $past(i_stop_req)) else $error("abort");
    stop_err_a: assert property ((o_engine_abort && !i_wr) ##1 st_rd
        |=> o_rd_data[fcsl_pkg::BIT_ACCERR]) else $error("stop gave no error");
    err_clear_a: assert property ((st_wr && i_wr_data[fcsl_pkg::BIT_ACCERR]
        && !i_wr_data[fcsl_pkg::BIT_CBEF] && !i_stop_req) ##1 (!i_wr && !i_stop_req) ##1 st_rd
        |=> !o_rd_data[fcsl_pkg::BIT_ACCERR]) else $error("error not cleared");
    busy_ccf_a: assert property ((o_cmd.start && !i_engine_done && !i_stop_req) ##1 st_rd
        |=> !o_rd_data[fcsl_pkg::BIT_CCF]) else $error("complete high at start");
    div_copy_a: assert property (i_wr && i_addr == fcsl_pkg::OFS_CLK_DIV
        |=> o_clk_div == $past(i_wr_data)) else $error("divider not copied");
    cover property (o_cmd.start);
    cover property (o_engine_abort);
    cover property (o_irq);
endmodule : fcsl_asserts
bind fcsl_top fcsl_asserts fcsl_asserts_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_engine_done(i_engine_done), .i_stop_req(i_stop_req), .o_cmd(o_cmd),
    .o_engine_abort(o_engine_abort),
    .o_clk_div(o_clk_div), .o_irq(o_irq));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst, wr, rd, done, erased, stop, abort, irq, e;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, clk_div, q, c, d, last_code;
    logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
    fcsl_pkg::fcsl_cmd_t cmd;
    int n_mismatch = 0, n_checks = 0, seed = 56, cyc = 0, n_start = 0, n_abort = 0;
    fcsl_top fcsl_top_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_engine_done(done), .i_array_erased(erased),
        .i_stop_req(stop), .o_cmd(cmd), .o_engine_abort(abort), .o_clk_div(clk_div), .o_irq(irq));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // start counted per cycle, so a stretched pulse shows up as an extra start
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd.start === 1'b1) begin
            n_start <= n_start + 1;
            last_code <= cmd.code;
        end
        if (abort === 1'b1) n_abort <= n_abort + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        n_checks++;
        if (g !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask : bus_rd
    task automatic go(input logic [7:0] k);
        bus_wr(3'h1, k);
        bus_wr(3'h0, 8'h80);
    endtask : go
    task automatic fin(input logic er);
        @(posedge clk);
        done <= 1'b1; erased <= er;
        @(posedge clk);
        done <= 1'b0; erased <= ~er;
    endtask : fin
    function automatic bit legal(input logic [7:0] k);
        return k inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
    endfunction : legal
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
        done = 1'b0; erased = 1'b0; stop = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus_rd(3'h0); chk("status", 8'hC0, q);
        chk("div", 8'h00, clk_div);
        bus_wr(3'h4, 8'h02); bus_wr(3'h3, 8'h03);
        for (int k = 0; k < 16; k++) begin
            c = 8'($random(seed));
            if (!legal(c)) begin
                bus_wr(3'h1, c); bus_rd(3'h0); chk("status", 8'hD0, q);
                chk("irq", 8'h01, {7'h00, irq});
                bus_wr(3'h0, 8'h00); bus_rd(3'h0); chk("status", 8'hD0, q);
                bus_wr(3'h0, 8'h10); bus_rd(3'h0); chk("status", 8'hC0, q);
                bus_wr(3'h3, 8'h03);
            end
        end
        bus_rd(3'h7); chk("unmapped", 8'h00, q);
        chk("irq", 8'h00, {7'h00, irq});
        $display("code error tests end");
        bus_wr(3'h1, 8'h20); bus_rd(3'h0); chk("status", 8'hD0, q);
        bus_wr(3'h0, 8'h10); bus_wr(3'h0, 8'h80); bus_rd(3'h0); chk("status", 8'hD0, q);
        bus_wr(3'h0, 8'h10); bus_wr(3'h3, 8'h03);
        go(8'h05); fin(1'b1); bus_rd(3'h0); chk("status", 8'hC4, q);
        bus_wr(3'h0, 8'h04); bus_wr(3'h0, 8'h00); bus_rd(3'h0); chk("status", 8'hC4, q);
        d = 8'($random(seed)) | 8'h01;
        bus_wr(3'h2, d); bus_rd(3'h2); chk("div", d, clk_div);
        chk("div_read", d, q);
        $display("sequence tests end");
        for (int i = 0; i < 6; i++) begin // mass erase not followed by blank check
            c = codes[i];
            e = 1'($random(seed));
            go(c); bus_rd(3'h0); chk("busy", 8'h00, q & 8'h44);
            chk("code", c, last_code);
            fin(e); bus_rd(3'h0); chk("status", (c == 8'h05 && e) ? 8'hC4 : 8'hC0, q);
        end
        chk("starts", 8'h07, n_start[7:0]);
        bus_rd(3'h3); chk("irq_status", 8'h01, q);
        chk("irq", 8'h00, {7'h00, irq});
        bus_wr(3'h4, 8'h03); bus_rd(3'h3); chk("irq", 8'h01, {7'h00, irq});
        bus_wr(3'h3, 8'h01); bus_rd(3'h3); chk("irq", 8'h00, {7'h00, irq});
        $display("command tests end");
        go(8'h40);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        bus_rd(3'h0); chk("error", 8'h10, q & 8'h10);
        chk("aborts", 8'h01, n_abort[7:0]);
        $display("stop test end");
        // second launch while busy waits in the buffer
        bus_wr(3'h0, 8'h10); go(8'h05); go(8'h20);
        bus_rd(3'h0); chk("queued", 8'h00, q);
        fin(1'b1); bus_rd(3'h0); chk("status", 8'h84, q);
        chk("code", 8'h20, last_code);
        fin(1'b0); bus_rd(3'h0); chk("status", 8'hC4, q);
        $display("queue test end");
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus_rd(3'h0); chk("status", 8'hC0, q);
        chk("div", 8'h00, clk_div);
        $display("reset test end");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
